//--- hdl/fdr_consts.vh
// Purpose: constants for the fractional divider ratio configuration block
// Assumes: byte-wide serial register writes, byte 0 holds bits 7:0
// Notes: definitions only
`ifndef FDR_CONSTS_VH
`define FDR_CONSTS_VH

// ----------------------------------------------------------------------
// register selection and byte lanes
// ----------------------------------------------------------------------
`define FDR_SEL_RATIO 1'h0
`define FDR_SEL_PHASE 1'h1
`define FDR_COMMIT_BYTE 3'h7
`define FDR_PHASE_HI_BYTE 3'h1

// ----------------------------------------------------------------------
// ratio configuration field positions
// ----------------------------------------------------------------------
`define FDR_POWER_DOWN_BIT 63
`define FDR_DISABLE_BIT 62
`define FDR_DIV_RESET_BIT 61
`define FDR_ACC_RESET_BIT 60
`define FDR_FRAC_MSB 59
`define FDR_FRAC_LSB 26
`define FDR_SECOND_MSB 25
`define FDR_SECOND_LSB 9
`define FDR_FIRST_MSB 8
`define FDR_FIRST_LSB 0

// ----------------------------------------------------------------------
// companion phase register
// ----------------------------------------------------------------------
`define FDR_SLOW_FREQ_BIT 13
`define FDR_SLOW_FREQ_BYTE_BIT 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FDR_RATIO_RESET 64'h0000_0000_0000_0064
`define FDR_FIRST_RESET 9'h064
`define FDR_SLOW_FREQ_RESET 1'h0

`endif

//--- hdl/fdr_ratio_config.v
// Purpose: configuration and control of one two-stage fractional output divider
// Assumes: byte writes from the serial register interface, inputs synchronous to clk_sys
// Notes: mmd_tick stands for one first-stage output period
//   integer ratio and fraction change only on the top-byte write
//   software sequencing of reset with power-down and disable is not enforced
//
// Operation
// - regulator off while power-down bit is one, on while zero
// - divider stopped while disable bit is one, runs while zero
// - whole divider held in reset while bit 61 is one
// - sigma-delta accumulator cleared and held while bit 60 is one
// - bits 59:26 are the fraction over a denominator of two to the 34
// - integer and fraction applied together when fraction bits 33:30 are written
// - second stage divides by twice bits 25:9, zero bypasses it
// - bits 8:0 are the first-stage integer ratio, resetting to 0x64
// - slow-frequency enable is phase register bit 13, resetting to zero
`timescale 1ns/1ps
`default_nettype none
`include "fdr_consts.vh"

module fdr_ratio_config #(
  parameter FRAC_W = 34,
  parameter FIRST_W = 9,
  parameter SECOND_W = 17
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // byte register port
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire reg_sel,
  input wire [2:0] reg_byte,
  input wire [7:0] reg_wr_data,
  output reg [7:0] reg_rd_data,
  // first-stage period strobe
  input wire mmd_tick,
  // divider control
  output reg frac_div_power_down,
  output reg div_stop,
  output reg div_reset,
  output reg sdm_acc_clear,
  output reg slow_freq_en,
  // active ratios
  output reg [FIRST_W-1:0] frac_div_first_stage_ratio,
  output reg [FRAC_W-1:0] frac_div_fraction,
  output reg [SECOND_W-1:0] frac_div_second_stage_half_ratio,
  output reg second_stage_bypass,
  // modulated divider
  output reg [FIRST_W-1:0] multi_modulus_first_stage,
  output reg div_clk_out
);

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  reg [63:0] cfg_r;
  reg [7:0] phase_hi_r;
  reg [FRAC_W-1:0] acc_r;
  reg [SECOND_W-1:0] cnt_r;
  reg [63:0] cfg_nxt;
  reg [7:0] phase_hi_nxt;
  wire ratio_wr;
  wire phase_wr;
  wire commit;
  wire run;
  wire [FRAC_W:0] acc_sum;
  wire [FIRST_W-1:0] first_field;
  wire [FRAC_W-1:0] frac_field;
  wire [SECOND_W-1:0] second_field;
  wire [SECOND_W-1:0] cnt_inc;
  wire cnt_wrap;

  assign ratio_wr = reg_wr_en && (reg_sel == `FDR_SEL_RATIO);
  assign commit = ratio_wr && (reg_byte == `FDR_COMMIT_BYTE);

  // byte merge of the written lane
  always @* begin
    cfg_nxt = cfg_r;
    if (ratio_wr) begin
      cfg_nxt[reg_byte*8 +: 8] = reg_wr_data;
    end
  end

  // fields of the merged word, so each write acts at its own edge
  assign first_field = cfg_nxt[`FDR_FIRST_MSB:`FDR_FIRST_LSB];
  assign frac_field = cfg_nxt[`FDR_FRAC_MSB:`FDR_FRAC_LSB];
  assign second_field = cfg_nxt[`FDR_SECOND_MSB:`FDR_SECOND_LSB];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_r <= `FDR_RATIO_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // companion phase register
  // ----------------------------------------------------------------------
  assign phase_wr = reg_wr_en && (reg_sel == `FDR_SEL_PHASE) && (reg_byte == `FDR_PHASE_HI_BYTE);

  // only the slow-frequency bit of the high byte is kept
  always @* begin
    phase_hi_nxt = phase_hi_r;
    if (phase_wr) begin
      phase_hi_nxt = {2'h0, reg_wr_data[`FDR_SLOW_FREQ_BYTE_BIT], 5'h00};
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_hi_r <= {2'h0, `FDR_SLOW_FREQ_RESET, 5'h00};
    end else begin
      phase_hi_r <= phase_hi_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_sel == `FDR_SEL_RATIO) begin
        reg_rd_data <= cfg_r[reg_byte*8 +: 8];
      end else if (reg_byte == `FDR_PHASE_HI_BYTE) begin
        reg_rd_data <= phase_hi_r;
      end else begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      frac_div_power_down <= 1'h0;
      div_stop <= 1'h0;
      div_reset <= 1'h0;
      sdm_acc_clear <= 1'h0;
      slow_freq_en <= `FDR_SLOW_FREQ_RESET;
    end else begin
      frac_div_power_down <= cfg_nxt[`FDR_POWER_DOWN_BIT];
      div_stop <= cfg_nxt[`FDR_DISABLE_BIT];
      div_reset <= cfg_nxt[`FDR_DIV_RESET_BIT];
      sdm_acc_clear <= cfg_nxt[`FDR_ACC_RESET_BIT];
      slow_freq_en <= phase_hi_nxt[`FDR_SLOW_FREQ_BYTE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // active ratios
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      frac_div_first_stage_ratio <= `FDR_FIRST_RESET;
      frac_div_fraction <= {FRAC_W{1'h0}};
      frac_div_second_stage_half_ratio <= {SECOND_W{1'h0}};
      second_stage_bypass <= 1'h1;
    end else begin
      frac_div_second_stage_half_ratio <= second_field;
      second_stage_bypass <= (second_field == {SECOND_W{1'h0}});
      // integer and fraction move only together
      if (commit) begin
        frac_div_first_stage_ratio <= first_field;
        frac_div_fraction <= frac_field;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sigma-delta modulation
  // ----------------------------------------------------------------------
  // divider runs only when powered, enabled and out of reset
  assign run = !frac_div_power_down && !div_stop && !div_reset;
  // carry out of the accumulator adds one to the modulus, denominator 2^34
  assign acc_sum = {1'h0, acc_r} + {1'h0, frac_div_fraction};

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_r <= {FRAC_W{1'h0}};
      multi_modulus_first_stage <= `FDR_FIRST_RESET;
    end else if (div_reset || sdm_acc_clear) begin
      acc_r <= {FRAC_W{1'h0}};
      multi_modulus_first_stage <= frac_div_first_stage_ratio;
    end else if (run && mmd_tick) begin
      acc_r <= acc_sum[FRAC_W-1:0];
      multi_modulus_first_stage <= frac_div_first_stage_ratio + {{(FIRST_W-1){1'h0}}, acc_sum[FRAC_W]};
    end
  end

  // ----------------------------------------------------------------------
  // second stage
  // ----------------------------------------------------------------------
  // toggle every half-ratio ticks gives a period of twice the field
  assign cnt_inc = cnt_r + {{(SECOND_W-1){1'h0}}, 1'h1};
  assign cnt_wrap = second_stage_bypass || (cnt_inc >= frac_div_second_stage_half_ratio);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r <= {SECOND_W{1'h0}};
      div_clk_out <= 1'h0;
    end else if (!run) begin
      cnt_r <= {SECOND_W{1'h0}};
      div_clk_out <= 1'h0;
    end else if (mmd_tick) begin
      if (cnt_wrap) begin
        cnt_r <= {SECOND_W{1'h0}};
        div_clk_out <= ~div_clk_out;
      end else begin
        cnt_r <= cnt_inc;
      end
    end
  end

endmodule
`default_nettype wire

//--- verif/fdr_ratio_config_props.sv
// Purpose: port assertions for fdr_ratio_config
// Assumes: single clk_sys domain, rst_n synchronous active low
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module fdr_ratio_config_props (
  // clock, reset, register port
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_sel,
  input wire logic [2:0] reg_byte,
  input wire logic [7:0] reg_wr_data,
  input wire logic mmd_tick,
  // divider outputs
  input wire logic frac_div_power_down,
  input wire logic div_stop,
  input wire logic div_reset,
  input wire logic sdm_acc_clear,
  input wire logic slow_freq_en,
  input wire logic [8:0] frac_div_first_stage_ratio,
  input wire logic [16:0] frac_div_second_stage_half_ratio,
  input wire logic second_stage_bypass,
  input wire logic div_clk_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_top_wr; reg_wr_en && !reg_sel && reg_byte == 3'h7; endsequence
  sequence s_low_wr; reg_wr_en && !reg_sel && reg_byte != 3'h7; endsequence
  wire halted = frac_div_power_down || div_stop || div_reset;
  a_pd_level: assert property (s_top_wr |=> frac_div_power_down == $past(reg_wr_data[7]))
    else $error("power down level");
  a_rst_level: assert property (s_top_wr |=> div_reset == $past(reg_wr_data[5]))
    else $error("divider reset level");
  a_acc_level: assert property (s_top_wr |=> sdm_acc_clear == $past(reg_wr_data[4]))
    else $error("accumulator clear level");
  a_bypass_map: assert property (second_stage_bypass == (frac_div_second_stage_half_ratio == 17'h0))
    else $error("bypass mismatch");
  a_shadow_hold: assert property (s_low_wr |=> $stable(frac_div_first_stage_ratio))
    else $error("ratio changed early");
  a_halt_quiet: assert property (halted |=> !div_clk_out)
    else $error("output while halted");
  a_bypass_tick: assert property (!halted && second_stage_bypass && mmd_tick |=> $changed(div_clk_out))
    else $error("bypass no toggle");
  a_slow_level: assert property (reg_wr_en && reg_sel && reg_byte == 3'h1 |=> slow_freq_en == $past(reg_wr_data[5]))
    else $error("slow enable");
endmodule
bind fdr_ratio_config fdr_ratio_config_props u_props (.*);
`default_nettype wire

//--- verif/fdr_ratio_config_test.sv
// Purpose: self-checking bench for fdr_ratio_config
// Assumes: byte accesses driven on the falling edge
// Notes: expectations sliced from the written word
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module fdr_ratio_config_test;
  logic clk_sys = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, reg_sel = 0, mmd_tick = 0;
  logic [2:0] reg_byte = 0;
  logic [7:0] reg_wr_data = 0, reg_rd_data;
  logic pd, stp, drst, acc, slow, byp, dclk;
  logic [8:0] r1, mm;
  logic [33:0] fr;
  logic [16:0] r2;
  int fails = 0, checks_done = 0;
  logic [63:0] v = 64'h0ABC_DEF1_2345_612A;
  always #2 clk_sys = ~clk_sys;
  fdr_ratio_config dut (.clk_sys, .rst_n, .reg_wr_en, .reg_rd_en, .reg_sel, .reg_byte, .reg_wr_data, .reg_rd_data,
    .mmd_tick, .frac_div_power_down(pd), .div_stop(stp), .div_reset(drst), .sdm_acc_clear(acc), .slow_freq_en(slow),
    .frac_div_first_stage_ratio(r1), .frac_div_fraction(fr), .frac_div_second_stage_half_ratio(r2),
    .second_stage_bypass(byp), .multi_modulus_first_stage(mm), .div_clk_out(dclk));
  task automatic wr(input logic s, input logic [2:0] b, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr_en, reg_sel, reg_byte, reg_wr_data} = {1'b1, s, b, d};
    @(negedge clk_sys);
    reg_wr_en = 0;
  endtask
  task automatic rd(input logic s, input logic [2:0] b, input logic [7:0] e);
    @(negedge clk_sys);
    {reg_rd_en, reg_sel, reg_byte} = {1'b1, s, b};
    @(negedge clk_sys);
    reg_rd_en = 0;
    `CHK(reg_rd_data, e)
  endtask
  task automatic tick();
    @(negedge clk_sys);
    mmd_tick = 1;
    @(negedge clk_sys);
    mmd_tick = 0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    for (int i = 0; i < 8; i++) rd(0, i[2:0], i == 0 ? 8'h64 : 8'h00);
    `CHK({r1, byp, pd, stp, drst, acc, slow, dclk}, {9'h064, 7'h40})
    `CHK({mm, fr, r2}, {9'h064, 34'h0, 17'h0})
    rd(1, 1, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 7; i++) wr(0, i[2:0], v[8*i +: 8]);
    `CHK(r1, 9'h064)
    wr(0, 7, v[63:56]);
    `CHK({r1, fr}, {v[8:0], v[59:26]})
    `CHK({r2, byp}, {v[25:9], 1'b0})
    for (int i = 0; i < 8; i++) rd(0, i[2:0], v[8*i +: 8]);
    $display("atomic ratio done");
    for (int i = 4; i < 8; i++) begin
      wr(0, 7, 8'h2A | (8'h01 << i));
      `CHK({pd, stp, drst, acc}, 4'h2 | (4'h1 << (i - 4)))
      wr(0, 7, 8'h2A);
      wr(0, 7, 8'h0A);
      `CHK({pd, stp, drst, acc}, 4'h0)
    end
    $display("control bits done");
    wr(0, 1, 8'h00);
    wr(0, 2, 8'h00);
    wr(0, 3, v[31:24] & 8'hFC);
    `CHK(byp, 1'h1)
    for (int i = 0; i < 3; i++) begin
      tick();
      `CHK(dclk, ~i[0])
    end
    wr(0, 7, 8'h6A);
    tick();
    `CHK(dclk, 1'h0)
    $display("divider done");
    wr(0, 0, 8'h20);
    wr(0, 1, 8'h04);
    for (int i = 3; i < 7; i++) wr(0, i[2:0], 8'h00);
    wr(0, 7, 8'h28);
    `CHK({r1, fr, r2, byp, drst}, {9'h020, 34'h2_0000_0000, 17'h00002, 2'h1})
    wr(0, 7, 8'h08);
    `CHK(mm, 9'h020)
    for (int i = 0; i < 3; i++) begin
      tick();
      `CHK({mm, dclk}, {9'h020 | {8'h00, i[0]}, i[0] ^ i[1]})
    end
    wr(0, 7, 8'h18);
    `CHK(acc, 1'h1)
    tick();
    `CHK(mm, 9'h020)
    wr(0, 7, 8'h08);
    for (int i = 0; i < 2; i++) begin
      tick();
      `CHK(mm, 9'h020 | {8'h00, i[0]})
    end
    $display("modulation done");
    wr(1, 1, 8'hFF);
    `CHK(slow, 1'h1)
    rd(1, 1, 8'h20);
    wr(1, 0, 8'hFF);
    `CHK(slow, 1'h1)
    rd(1, 0, 8'h00);
    wr(1, 1, 8'hDF);
    `CHK(slow, 1'h0)
    rd(1, 1, 8'h00);
    $display("phase register done");
    final_report();
  end
endmodule
`default_nettype wire
